// File: rtl/lbr_map.svh
// constants of the lcd bias, reset and drive control block
`ifndef LBR_MAP_SVH
`define LBR_MAP_SVH
`define LBR_DUTY_QUARTER 2'h0
`define LBR_DUTY_SIXTH 2'h1
`define LBR_DUTY_FIFTH 2'h2
`define LBR_COMS_QUARTER 3'h4
`define LBR_COMS_SIXTH 3'h6
`define LBR_COMS_FIFTH 3'h5
`define LBR_SRC_EXT_PIN 2'h0
`define LBR_SRC_REF_LOW 2'h1
`define LBR_SRC_VDD_MID 2'h2
`define LBR_SRC_VDD_TOP 2'h3
`define LBR_RES_1170K 3'h0
`define LBR_RES_225K 3'h1
`define LBR_RES_45K 3'h2
`define LBR_RES_QC_1170K 3'h3
`define LBR_LVL_GND 2'h0
`define LBR_LVL_C 2'h1
`define LBR_LVL_B 2'h2
`define LBR_LVL_A 2'h3
`define LBR_LCD_CLK_DIV 4'h8
`define LBR_RST_CTRL 10'h000
`endif

// File: rtl/lbr_pkg.sv
// types of the lcd bias, reset and drive control block
`default_nettype none
package lbr_pkg;
	typedef struct packed {
		logic wave_type_b;
		logic [1:0] duty_sel;
		logic [2:0] pump_clk_div;
	} lbr_frame_cfg_t;
	typedef struct packed {
		logic ladder_on;
		logic pump_on;
		logic [2:0] resistor;
		logic [1:0] pump_source_sel;
	} lbr_bias_t;
	typedef enum logic [2:0] {
		LBR_OFF = 3'h1,
		LBR_FLOAT = 3'h2,
		LBR_RUN = 3'h4
	} lbr_state_t;
endpackage
`default_nettype wire

// File: rtl/lbr_ctrl.sv
// lcd bias selection, lcd reset and com/seg waveform generator
`include "lbr_map.svh"
`default_nettype none
// Function
// [RULE1] bias_kind_select picks ladder or pump bias and pump bias turns the pump on.
// [RULE2] in ladder mode the resistor output follows ladder_resistor_sel.
// [RULE3] in pump mode the supply source output follows pump_source_sel.
// [RULE4] the pump clock is the sub-clock divided as pump_clk_div selects.
// [RULE5] the lcd reset is not display_on or sleep.
// [RULE6] entering sleep or clearing display_on resets the lcd function.
// [RULE7] com and seg drive normally when running and drive low in lcd reset.
// [RULE8] com and seg float during mcu reset, except a watchdog reset in idle or sleep.
// [RULE9] every pixel sees zero mean voltage by alternating polarity each frame.
// [RULE10] a frame has one slot per common in use.
// [RULE11] type a inverts every slot pair, type b every frame, giving a lower frequency; the code inverts type a each half slot.
// [RULE12] only one third bias with four levels: ground and three bias levels.
// [RULE13] duty 00 is four, 01 six, 10 five commons, 11 is unimplemented.
// [RULE14] pump divider codes 000 to 111 give /128 /64 /32 /16 /8 /4 /2 /2.
// [RULE15] quick charge uses the lowest resistor after each com change for 1 to 8 sub-clocks.
// [RULE16] source 00 external pin, 01 reference to low, 10 supply to mid, 11 supply to top.
// [RULE17] waveform type, duty and divider take effect only at a frame boundary.
module lbr_ctrl #(
	parameter int SEGS = 30,
	parameter int COMS = 6
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// system state
	input wire logic mcu_reset,
	input wire logic wdt_reset_low_power,
	input wire logic sleep_mode,
	input wire logic sub_clk_tick,
	// control bits
	input wire logic display_on,
	input wire logic bias_kind_select,
	input wire logic wave_type_b,
	input wire logic [1:0] pump_source_sel,
	input wire logic [2:0] ladder_resistor_sel,
	input wire logic [2:0] fast_charge_time,
	input wire logic [2:0] pump_clk_div,
	input wire logic [1:0] duty_sel,
	// pixel data, one bit per segment for each common
	input wire logic [SEGS-1:0] seg_data [COMS],
	// bias control
	output logic ladder_on,
	output logic pump_on,
	output logic [2:0] resistor_sel_out,
	output logic fast_charge_active,
	output logic [1:0] supply_source,
	output logic pump_clk,
	output logic lcd_reset,
	// pads: level codes plus enables
	output logic [1:0] com_level [COMS],
	output logic [COMS-1:0] com_oe,
	output logic [1:0] seg_level [SEGS],
	output logic [SEGS-1:0] seg_oe
);
	lbr_pkg::lbr_frame_cfg_t cfg;
	lbr_pkg::lbr_state_t state;
	lbr_pkg::lbr_state_t next_state;
	logic [2:0] sub_div;
	logic lcd_tick;
	logic [2:0] slot;
	logic [2:0] slot_count;
	logic phase;
	logic frame_pol;
	logic [6:0] pump_cnt;
	logic [3:0] qc_cnt;
	logic [2:0] pump_bit;
	logic frame_end;
	logic [1:0] hi_lvl;
	logic [1:0] lo_lvl;
	logic pol;
	logic [4:0] slot_ticks;

	assign lcd_reset = ~display_on | sleep_mode; // [RULE5]

	always_comb begin
		case (cfg.duty_sel) // [RULE13]
			`LBR_DUTY_SIXTH: slot_count = `LBR_COMS_SIXTH;
			`LBR_DUTY_FIFTH: slot_count = `LBR_COMS_FIFTH;
			default: slot_count = `LBR_COMS_QUARTER;
		endcase
	end

	always_comb begin
		// mcu reset outranks the lcd reset; a low-power watchdog reset does not float
		if (mcu_reset && !wdt_reset_low_power) begin
			next_state = lbr_pkg::LBR_FLOAT; // [RULE8]
		end else if (lcd_reset) begin
			next_state = lbr_pkg::LBR_OFF; // [RULE6]
		end else begin
			next_state = lbr_pkg::LBR_RUN;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= lbr_pkg::LBR_FLOAT;
		end else begin
			state <= next_state;
		end
	end

	// lcd clock is sub-clock / 8
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sub_div <= 3'h0;
		end else if (sub_clk_tick) begin
			sub_div <= sub_div + 3'h1;
		end
	end
	assign lcd_tick = sub_clk_tick && (sub_div == 3'(`LBR_LCD_CLK_DIV - 4'h1));

	// slot and phase sequencing
	assign frame_end = lcd_tick && phase && (slot == slot_count - 3'h1); // [RULE10]
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot <= 3'h0;
			phase <= 1'b0;
			frame_pol <= 1'b0;
		end else if (state != lbr_pkg::LBR_RUN) begin
			slot <= 3'h0;
			phase <= 1'b0;
		end else if (lcd_tick) begin
			phase <= ~phase;
			if (phase) begin
				slot <= frame_end ? 3'h0 : slot + 3'h1;
				if (frame_end) begin
					frame_pol <= ~frame_pol; // [RULE9]
				end
			end
		end
	end

	// sub ticks spent in the current slot, watched by a_slot_len
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_ticks <= 5'h00;
		end else if (state != lbr_pkg::LBR_RUN || (lcd_tick && phase)) begin
			slot_ticks <= 5'h00;
		end else if (sub_clk_tick) begin
			slot_ticks <= slot_ticks + 5'h01;
		end
	end

	// settings latched at frame boundary
	// a duty code of 11 keeps the duty in use
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= '0;
		end else if (frame_end || state != lbr_pkg::LBR_RUN) begin
			cfg.wave_type_b <= wave_type_b; // [RULE17]
			cfg.duty_sel <= (duty_sel == 2'h3) ? cfg.duty_sel : duty_sel; // [RULE13]
			cfg.pump_clk_div <= pump_clk_div;
		end
	end

	// bias selection
	assign pump_on = bias_kind_select & ~lcd_reset; // [RULE1]
	assign ladder_on = ~bias_kind_select & ~lcd_reset; // [RULE1]
	assign supply_source = bias_kind_select ? pump_source_sel : `LBR_SRC_EXT_PIN; // [RULE3] [RULE16]

	// pump clock divider
	// codes 110 and 111 both tap bit 0
	assign pump_bit = (cfg.pump_clk_div == 3'h7) ? 3'h0 : 3'h6 - cfg.pump_clk_div; // [RULE14]
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pump_cnt <= 7'h00;
		end else if (!pump_on) begin
			pump_cnt <= 7'h00;
		end else if (sub_clk_tick) begin
			pump_cnt <= pump_cnt + 7'h01; // [RULE4]
		end
	end
	assign pump_clk = pump_on & pump_cnt[pump_bit]; // [RULE4]

	// quick charge timer, restarted at each com change
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			qc_cnt <= 4'h0;
		end else if (lcd_tick && phase) begin
			qc_cnt <= {1'b0, fast_charge_time} + 4'h1; // [RULE15]
		end else if (sub_clk_tick && qc_cnt != 4'h0) begin
			qc_cnt <= qc_cnt - 4'h1;
		end
	end
	assign fast_charge_active = ladder_on && ladder_resistor_sel >= `LBR_RES_QC_1170K && qc_cnt != 4'h0;
	always_comb begin
		if (ladder_resistor_sel < `LBR_RES_QC_1170K) begin
			resistor_sel_out = ladder_resistor_sel; // [RULE2]
		end else if (fast_charge_active) begin
			resistor_sel_out = `LBR_RES_45K; // [RULE15]
		end else if (ladder_resistor_sel == `LBR_RES_QC_1170K) begin
			resistor_sel_out = `LBR_RES_1170K;
		end else begin
			resistor_sel_out = `LBR_RES_225K;
		end
	end

	// polarity: type a flips each half slot, type b each frame
	assign pol = cfg.wave_type_b ? frame_pol : phase; // [RULE11]
	assign hi_lvl = pol ? `LBR_LVL_GND : `LBR_LVL_A; // [RULE12]
	assign lo_lvl = pol ? `LBR_LVL_B : `LBR_LVL_C; // [RULE12]

	// pads follow next_state so a float request is honoured on the next edge
	genvar gi;
	generate
		for (gi = 0; gi < COMS; gi++) begin : g_com
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					com_level[gi] <= `LBR_LVL_GND;
					com_oe[gi] <= 1'b0;
				end else begin
					com_oe[gi] <= next_state != lbr_pkg::LBR_FLOAT; // [RULE8]
					if (next_state == lbr_pkg::LBR_RUN && 3'(gi) < slot_count) begin
						com_level[gi] <= (3'(gi) == slot) ? hi_lvl : lo_lvl; // [RULE9]
					end else begin
						com_level[gi] <= `LBR_LVL_GND; // [RULE7]
					end
				end
			end
		end
		for (gi = 0; gi < SEGS; gi++) begin : g_seg
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					seg_level[gi] <= `LBR_LVL_GND;
					seg_oe[gi] <= 1'b0;
				end else begin
					seg_oe[gi] <= next_state != lbr_pkg::LBR_FLOAT; // [RULE8]
					if (next_state != lbr_pkg::LBR_RUN) begin
						seg_level[gi] <= `LBR_LVL_GND; // [RULE7]
					end else if (seg_data[slot][gi]) begin
						seg_level[gi] <= pol ? `LBR_LVL_A : `LBR_LVL_GND; // [RULE9]
					end else begin
						seg_level[gi] <= pol ? `LBR_LVL_C : `LBR_LVL_B;
					end
				end
			end
		end
	endgenerate

	a_reset_or: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE5]
		lcd_reset == (!display_on || sleep_mode)) else $error("lcd reset wrong");
	a_float_mcu: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE8]
		(mcu_reset && !wdt_reset_low_power) |=> !com_oe[0] && !seg_oe[0]) else $error("pads not floating");
	a_low_off: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE7]
		(!mcu_reset && lcd_reset) |=> com_oe[0] && com_level[0] == `LBR_LVL_GND) else $error("com not low");
	a_pump_sel: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE1]
		pump_on |-> bias_kind_select && !ladder_on) else $error("bias kind wrong");
	a_src_follow: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE3]
		bias_kind_select |-> supply_source == pump_source_sel) else $error("source wrong");
	a_res_plain: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE2]
		ladder_resistor_sel < 3'h3 |-> resistor_sel_out == ladder_resistor_sel) else $error("resistor wrong");
	a_cfg_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE17]
		(state == lbr_pkg::LBR_RUN && !frame_end) |=> $stable(cfg)) else $error("cfg changed mid frame");
	a_slot_range: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE10]
		slot < 3'h6) else $error("slot out of range");
	a_duty_code: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE13]
		cfg.duty_sel != 2'h3) else $error("unimplemented duty latched");
	a_pol_frame: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE9]
		frame_end && state == lbr_pkg::LBR_RUN |=> frame_pol != $past(frame_pol)) else $error("no flip");

	a_reset_stops: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE6]
		lcd_reset |=> state != lbr_pkg::LBR_RUN) else $error("lcd reset ignored");
	a_reset_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE6]
		lcd_reset |-> ##2 (slot == 3'h0 && !phase)) else $error("sequencer not cleared");
	a_run_drive: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE7]
		(!mcu_reset && !lcd_reset) |=> com_oe[0] && seg_oe[0]) else $error("pads not driven");
	a_seg_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE7]
		(!mcu_reset && lcd_reset) |=> seg_oe[0] && seg_level[0] == `LBR_LVL_GND) else $error("seg not low");
	a_float_all: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE8]
		(mcu_reset && !wdt_reset_low_power) |=> com_oe == '0 && seg_oe == '0) else $error("pads driven");
	a_wdt_keep: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE8]
		(mcu_reset && wdt_reset_low_power) |=> com_oe[0] && seg_oe[0]) else $error("wdt floated pads");
	a_ladder_sel: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE1]
		ladder_on |-> !bias_kind_select && !pump_on) else $error("ladder with pump");
	a_src_ladder: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE16]
		!bias_kind_select |-> supply_source == `LBR_SRC_EXT_PIN) else $error("source not idle");
	a_qc_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE15]
		fast_charge_active |-> resistor_sel_out == `LBR_RES_45K) else $error("quick charge not lowest");
	a_qc_high: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE15]
		(ladder_resistor_sel >= `LBR_RES_QC_1170K && !fast_charge_active) |-> resistor_sel_out != `LBR_RES_45K)
		else $error("no switch back");
	a_qc_span: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE15]
		qc_cnt <= 4'h8) else $error("quick charge too long");
	a_pump_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE4]
		!pump_on |-> !pump_clk) else $error("pump clock while off");
	a_slot_limit: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE10]
		slot < slot_count) else $error("slot past duty");
	a_phase_flip: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE11]
		(state == lbr_pkg::LBR_RUN && lcd_tick) |=> phase != $past(phase)) else $error("phase stuck");
	a_pol_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE11]
		!frame_end |=> $stable(frame_pol)) else $error("polarity moved mid frame");
	a_slot_len: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE10]
		slot_ticks < 5'h10) else $error("slot too long");

	c_run: cover property (@(posedge sys_clk) disable iff (!rst_b) state == lbr_pkg::LBR_RUN && frame_end);
	c_sleep: cover property (@(posedge sys_clk) disable iff (!rst_b)
		state == lbr_pkg::LBR_RUN ##1 state == lbr_pkg::LBR_OFF);
	c_qc: cover property (@(posedge sys_clk) disable iff (!rst_b) fast_charge_active ##1 !fast_charge_active);
	c_pump: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(pump_clk));
	c_type_b: cover property (@(posedge sys_clk) disable iff (!rst_b) cfg.wave_type_b && frame_end);
endmodule
`default_nettype wire

// File: verification/lbr_glass.sv
// passive glass model integrating the voltage across one pixel
`default_nettype none
module lbr_glass #(
	parameter int SEGS = 30,
	parameter int COMS = 6
) (
	// pads seen by the glass
	input wire logic sys_clk,
	input wire logic [1:0] com_level [COMS],
	input wire logic [COMS-1:0] com_oe,
	input wire logic [1:0] seg_level [SEGS],
	input wire logic [SEGS-1:0] seg_oe,
	output var int dc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial dc = 0;
	// net charge on pixel com0/seg0, zero over whole inversion periods
	always @(posedge sys_clk) begin
		if (com_oe[0] && seg_oe[0]) begin
			dc <= dc + int'(com_level[0]) - int'(seg_level[0]);
		end
	end
endmodule
`default_nettype wire

// File: verification/lcd_bias_reset_drive_control_tb.sv
// self-checking bench of the lcd bias, reset and drive control block
`default_nettype none
module lcd_bias_reset_drive_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_b, mcu_reset, wdt_reset_low_power, sleep_mode, sub_clk_tick;
	logic display_on, bias_kind_select, wave_type_b;
	logic [1:0] pump_source_sel, duty_sel, supply_source;
	logic [2:0] ladder_resistor_sel, fast_charge_time, pump_clk_div, resistor_sel_out;
	logic [29:0] seg_data [6];
	logic ladder_on, pump_on, fast_charge_active, pump_clk, lcd_reset;
	logic [1:0] com_level [6];
	logic [5:0] com_oe;
	logic [1:0] seg_level [30];
	logic [29:0] seg_oe;
	int bad_count = 0, checks = 0, cyc = 0, dc, n, a, b;
	lbr_ctrl #(.SEGS(30), .COMS(6)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .mcu_reset(mcu_reset),
		.wdt_reset_low_power(wdt_reset_low_power), .sleep_mode(sleep_mode), .sub_clk_tick(sub_clk_tick),
		.display_on(display_on), .bias_kind_select(bias_kind_select), .wave_type_b(wave_type_b),
		.pump_source_sel(pump_source_sel), .ladder_resistor_sel(ladder_resistor_sel),
		.fast_charge_time(fast_charge_time), .pump_clk_div(pump_clk_div), .duty_sel(duty_sel),
		.seg_data(seg_data), .ladder_on(ladder_on), .pump_on(pump_on), .resistor_sel_out(resistor_sel_out),
		.fast_charge_active(fast_charge_active), .supply_source(supply_source), .pump_clk(pump_clk),
		.lcd_reset(lcd_reset), .com_level(com_level), .com_oe(com_oe), .seg_level(seg_level), .seg_oe(seg_oe));
	lbr_glass #(.SEGS(30), .COMS(6)) i_glass (.sys_clk(sys_clk), .com_level(com_level), .com_oe(com_oe),
		.seg_level(seg_level), .seg_oe(seg_oe), .dc(dc));
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	// sub-clock tick every fourth cycle; run time ceiling
	always @(negedge sys_clk) sub_clk_tick <= (cyc % 4 == 3);
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", s, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic start(input logic [1:0] d, input logic t);
		display_on = 1'h0;
		duty_sel = d;
		wave_type_b = t;
		tick(2);
		display_on = 1'h1;
		tick(4);
	endtask
	// cycles until com0 enters or leaves its selected slot
	task automatic wait_sel(input logic want, output int k);
		k = 0;
		while (((com_level[0] == 2'h0) || (com_level[0] == 2'h3)) !== want && k < 3000) begin
			tick(1);
			k++;
		end
	endtask
	task automatic t_bias();
		display_on = 1'h1;
		bias_kind_select = 1'h0;
		for (int k = 0; k < 3; k++) begin
			ladder_resistor_sel = k[2:0];
			tick(1);
			chk("ladder", {ladder_on, pump_on, resistor_sel_out}, {2'h2, k[2:0]});
		end
		bias_kind_select = 1'h1;
		for (int k = 0; k < 4; k++) begin
			pump_source_sel = k[1:0];
			tick(1);
			chk("pump", {ladder_on, pump_on, supply_source}, {2'h1, k[1:0]});
		end
	endtask
	task automatic t_modes();
		tick(4);
		chk("run", {lcd_reset, com_oe[0]}, 2'h1);
		display_on = 1'h0;
		tick(2);
		chk("off", {lcd_reset, com_oe[0], com_level[0]}, 4'hc);
		display_on = 1'h1;
		sleep_mode = 1'h1;
		tick(2);
		chk("sleep", {lcd_reset, com_oe[0], com_level[0]}, 4'hc);
		sleep_mode = 1'h0;
		mcu_reset = 1'h1;
		tick(2);
		chk("float", com_oe[0], 1'h0);
		wdt_reset_low_power = 1'h1;
		tick(2);
		chk("wdt", com_oe[0], 1'h1);
		mcu_reset = 1'h0;
		wdt_reset_low_power = 1'h0;
	endtask
	task automatic t_duty(input logic [1:0] d, input int coms);
		if (d != 2'h3) start(d, 1'h0);
		else begin
			duty_sel = d;
			tick(700);
		end
		wait_sel(1'h1, n);
		wait_sel(1'h0, n);
		wait_sel(1'h1, n);
		chk("slots", (n + 32) / 64 + 1, coms);
	endtask
	task automatic t_wave(input logic t, output int ch);
		logic [1:0] prev;
		int base;
		start(2'h0, t);
		base = dc;
		ch = 0;
		prev = com_level[0];
		repeat (512) begin
			tick(1);
			if (com_level[0] !== prev) ch++;
			prev = com_level[0];
		end
		chk("dc", dc - base, 0);
	endtask
	task automatic t_pump();
		for (int k = 0; k < 8; k++) begin
			pump_clk_div = k[2:0];
			tick(700);
			n = 0;
			a = (k == 7) ? 256 : 512 >> (7 - k);
			repeat (2048) begin
				b = pump_clk;
				tick(1);
				if (pump_clk && b == 0) n++;
			end
			chk("pumpclk", n >= a - 1 && n <= a + 1, 1'h1);
		end
	endtask
	task automatic t_quick(input logic [2:0] t);
		int m;
		bias_kind_select = 1'h0;
		ladder_resistor_sel = 3'h4;
		fast_charge_time = t;
		tick(300);
		n = 0;
		m = 0;
		repeat (512) begin
			tick(1);
			if (fast_charge_active === 1'h1) n++;
			if (resistor_sel_out !== ((fast_charge_active === 1'h1) ? 3'h2 : 3'h1)) m++;
		end
		a = 32 * (int'(t) + 1);
		chk("quick", n >= a - 8 && n <= a + 8, 1'h1);
		chk("quick_res", m, 0);
	endtask
	initial begin
		{rst_b, mcu_reset, wdt_reset_low_power, sleep_mode, display_on, bias_kind_select, wave_type_b} = 7'h0;
		{pump_source_sel, duty_sel, ladder_resistor_sel, fast_charge_time, pump_clk_div} = 13'h0;
		foreach (seg_data[k]) seg_data[k] = 30'h1;
		tick(11);
		chk("rst_float", com_oe, 6'h0);
		tick(1);
		rst_b = 1'h1;
		t_bias();
		t_modes();
		t_duty(2'h0, 4);
		t_duty(2'h1, 6);
		t_duty(2'h2, 5);
		t_duty(2'h3, 5);
		t_wave(1'h0, a);
		t_wave(1'h1, b);
		chk("type_b_slower", a > b, 1'h1);
		t_pump();
		t_quick(3'h0);
		t_quick(3'h7);
		stop_test();
	end
endmodule
`default_nettype wire
